// File: cfr_top.sv
// AHB-Lite register block: receive payload, error tally and acceptance filters
//
// The register offsets and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
module cfr_top (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire cfr_pkg::cfr_rxid_s rx_id,
   input wire cfr_pkg::cfr_errev_s rx_err,
   input wire logic rx_byte_we,
   input wire logic [3:0] rx_byte_sel,
   input wire logic [7:0] rx_byte_data,
   input wire logic [cfr_pkg::CFR_NMASK-1:0][17:0] mask_ext_lower,
   input wire logic other_passive,
   output logic error_passive,
   output logic accept_valid,
   output logic [cfr_pkg::CFR_NFILT-1:0] accept_hits,
   output logic irq
);
   import cfr_pkg::*;

   cfr_state_s st;
   cfr_state_s next_st;
   logic take;
   logic take_rd;
   logic [11:0] a;
   logic [11:0] d;
   logic [31:0] rd;
   logic [CFR_NSTATUS-1:0] ev;
   logic [CFR_NFILT-1:0] hit;
   logic [28:0] fid;
   logic [28:0] mid;
   logic [28:0] diff;
   int mk;

   assign take = ce && hsel && hready && htrans == CFR_HTRANS_NONSEQ;
   assign take_rd = take && !hwrite;
   assign a = haddr[11:0];
   assign d = st.ap_addr;

   always_comb begin
      next_st = st;
      ev = '0;
      hit = '0;
      fid = '0;
      mid = '0;
      diff = '0;
      mk = 0;
      rd = '0;
      // Receive error tally, errors take priority over a good frame
      if (rx_err.major) begin
         next_st.tally = (st.tally > CFR_TALLY_MAX - CFR_TALLY_MAJOR) ? CFR_TALLY_MAX : st.tally + CFR_TALLY_MAJOR;
      end else if (rx_err.minor) begin
         next_st.tally = (st.tally == CFR_TALLY_MAX) ? CFR_TALLY_MAX : st.tally + CFR_TALLY_MINOR;
      end else if (rx_err.success) begin
         if (st.tally > CFR_PASSIVE_LIMIT) begin
            next_st.tally = CFR_PASSIVE_LIMIT;
         end else if (st.tally != 8'h00) begin
            next_st.tally = st.tally - CFR_TALLY_MINOR;
         end
      end
      // Tally only drives passive; no bus-off path exists here
      next_st.passive = (st.tally > CFR_PASSIVE_LIMIT) || other_passive;
      if (next_st.passive && !st.passive) begin
         ev[CFR_ST_PASSIVE] = 1'b1;
      end
      // Acceptance filtering
      if (rx_id.valid) begin
         for (int f = 0; f < CFR_NFILT; f++) begin
            mk = (f < CFR_MASK0_FILTERS) ? 0 : 1;
            fid = {st.f_id_high[f], st.f_id_low[f][7:5], st.f_id_low[f][1:0],
                   st.f_ext_high[f], st.f_ext_low[f]};
            mid = {st.m_id_high[mk], st.m_id_low[mk][7:5], mask_ext_lower[mk]};
            diff = (fid ^ rx_id.id) & mid;
            if (!rx_id.ext) begin
               diff[17:0] = '0;
            end
            hit[f] = (rx_id.ext == st.f_id_low[f][CFR_SIDL_EXT_BIT]) && diff == '0;
         end
      end
      next_st.acc_valid = rx_id.valid;
      next_st.acc_hits = hit;
      if (|hit) begin
         ev[CFR_ST_ACCEPT] = 1'b1;
      end
      // Hardware stores a received payload byte
      if (rx_byte_we) begin
         next_st.payload[rx_byte_sel] = rx_byte_data;
      end
      // Data phase of a write
      if (st.ap_wr) begin
         if (d[11:6] == CFR_PAGE_PAYLOAD && !(rx_byte_we && rx_byte_sel == d[5:2])) begin
            next_st.payload[d[5:2]] = hwdata[7:0];
         end else if (d == CFR_OFS_IRQ_MASK) begin
            next_st.irq_mask = hwdata[CFR_NSTATUS-1:0];
         end else if (d[11:7] == CFR_PAGE_FILTER && int'(d[6:4]) < CFR_NFILT) begin
            unique case (d[3:2])
               CFR_FREG_ID_HIGH: next_st.f_id_high[d[6:4]] = hwdata[7:0];
               CFR_FREG_ID_LOW: next_st.f_id_low[d[6:4]] = hwdata[7:0] & CFR_FILTER_LOW_WMASK;
               CFR_FREG_EXT_HIGH: next_st.f_ext_high[d[6:4]] = hwdata[7:0];
               CFR_FREG_EXT_LOW: next_st.f_ext_low[d[6:4]] = hwdata[7:0];
            endcase
         end else if (d[11:4] == CFR_PAGE_MASK) begin
            if (d[2]) begin
               next_st.m_id_low[d[3]] = hwdata[7:0] & CFR_MASK_LOW_WMASK;
            end else begin
               next_st.m_id_high[d[3]] = hwdata[7:0];
            end
         end
      end
      // Sticky events; a read clears them after reporting, so a new set is never lost
      next_st.status = st.status | ev;
      if (take_rd) begin
         if (a[11:6] == CFR_PAGE_PAYLOAD) begin
            rd[7:0] = next_st.payload[a[5:2]];
         end else if (a == CFR_OFS_TALLY) begin
            rd[7:0] = next_st.tally;
         end else if (a == CFR_OFS_STATUS) begin
            rd[CFR_NSTATUS-1:0] = next_st.status;
            next_st.status = ev & ~st.status;
         end else if (a == CFR_OFS_IRQ_MASK) begin
            rd[CFR_NSTATUS-1:0] = next_st.irq_mask;
         end else if (a[11:7] == CFR_PAGE_FILTER && int'(a[6:4]) < CFR_NFILT) begin
            unique case (a[3:2])
               CFR_FREG_ID_HIGH: rd[7:0] = next_st.f_id_high[a[6:4]];
               CFR_FREG_ID_LOW: rd[7:0] = next_st.f_id_low[a[6:4]] & CFR_FILTER_LOW_WMASK;
               CFR_FREG_EXT_HIGH: rd[7:0] = next_st.f_ext_high[a[6:4]];
               CFR_FREG_EXT_LOW: rd[7:0] = next_st.f_ext_low[a[6:4]];
            endcase
         end else if (a[11:4] == CFR_PAGE_MASK) begin
            rd[7:0] = a[2] ? (next_st.m_id_low[a[3]] & CFR_MASK_LOW_WMASK) : next_st.m_id_high[a[3]];
         end
         next_st.rdata = rd;
      end
      next_st.ap_wr = take && hwrite;
      if (take) begin
         next_st.ap_addr = a;
      end
      next_st.ready = 1'b1;
      next_st.resp = 1'b0;
      next_st.irq = |(next_st.status & st.irq_mask);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st <= CFR_ST_RESET;
      end else if (ce) begin
         st <= next_st;
      end
   end

   assign hrdata = st.rdata;
   assign hreadyout = st.ready;
   assign hresp = st.resp;
   assign error_passive = st.passive;
   assign accept_valid = st.acc_valid;
   assign accept_hits = st.acc_hits;
   assign irq = st.irq;

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   property p_payload_write;
      ce && st.ap_wr && st.ap_addr[11:6] == CFR_PAGE_PAYLOAD && !rx_byte_we
      |=> st.payload[$past(st.ap_addr[5:2])] == $past(hwdata[7:0]);
   endproperty
   a_payload_write: assert property (p_payload_write) else $error("payload byte not stored");

   property p_tally_read;
      ce && take_rd && a == CFR_OFS_TALLY && !rx_err.major && !rx_err.minor && !rx_err.success
      |=> hrdata == {24'h000000, $past(st.tally)};
   endproperty
   a_tally_read: assert property (p_tally_read) else $error("tally read wrong");

   property p_passive_enter;
      ce && st.tally > CFR_PASSIVE_LIMIT |=> error_passive;
   endproperty
   a_passive_enter: assert property (p_passive_enter) else $error("passive not entered");

   property p_tally_saturate;
      ce && st.tally == CFR_TALLY_MAX && rx_err.major |=> st.tally == CFR_TALLY_MAX ##0 error_passive;
   endproperty
   a_tally_saturate: assert property (p_tally_saturate) else $error("tally wrapped");

   property p_passive_leave;
      ce && st.tally <= CFR_PASSIVE_LIMIT && !other_passive |=> !error_passive;
   endproperty
   a_passive_leave: assert property (p_passive_leave) else $error("passive not left");

   property p_kind_select;
      ce && rx_id.valid && rx_id.ext != st.f_id_low[0][CFR_SIDL_EXT_BIT] |=> accept_valid && !accept_hits[0];
   endproperty
   a_kind_select: assert property (p_kind_select) else $error("wrong frame kind accepted");

   property p_std_low;
      ce && rx_id.valid && !rx_id.ext && !st.f_id_low[0][CFR_SIDL_EXT_BIT]
      && ((rx_id.id[20:18] ^ st.f_id_low[0][7:5]) & st.m_id_low[0][7:5]) != 3'h0 |=> !accept_hits[0];
   endproperty
   a_std_low: assert property (p_std_low) else $error("standard low bits ignored");

   property p_ext_low;
      ce && rx_id.valid && rx_id.ext && st.f_id_low[0][CFR_SIDL_EXT_BIT]
      && ((rx_id.id[20:16] ^ {st.f_id_low[0][7:5], st.f_id_low[0][1:0]})
      & {st.m_id_low[0][7:5], mask_ext_lower[0][17:16]}) != 5'h00 |=> !accept_hits[0];
   endproperty
   a_ext_low: assert property (p_ext_low) else $error("extended low bits ignored");

   property p_low_holes;
      ce && take_rd && a[11:7] == CFR_PAGE_FILTER && a[3:2] == CFR_FREG_ID_LOW
      |=> hrdata[4] == 1'b0 && hrdata[2] == 1'b0;
   endproperty
   a_low_holes: assert property (p_low_holes) else $error("unimplemented bits not zero");

   property p_payload_hw;
      ce && rx_byte_we |=> st.payload[$past(rx_byte_sel)] == $past(rx_byte_data);
   endproperty
   a_payload_hw: assert property (p_payload_hw) else $error("hardware payload byte not stored");

   property p_payload_read;
      ce && take_rd && a[11:6] == CFR_PAGE_PAYLOAD && !rx_byte_we && !st.ap_wr
      |=> hrdata == {24'h000000, $past(st.payload[a[5:2]])};
   endproperty
   a_payload_read: assert property (p_payload_read) else $error("payload read wrong");

   property p_payload_upper;
      ce && take_rd && a[11:6] == CFR_PAGE_PAYLOAD
      |=> hrdata[31:8] == 24'h000000;
   endproperty
   a_payload_upper: assert property (p_payload_upper) else $error("payload upper bits not zero");

   property p_tally_major;
      ce && rx_err.major && st.tally <= CFR_TALLY_MAX - CFR_TALLY_MAJOR
      |=> st.tally == $past(st.tally) + CFR_TALLY_MAJOR;
   endproperty
   a_tally_major: assert property (p_tally_major) else $error("major error step wrong");

   property p_tally_minor;
      ce && rx_err.minor && !rx_err.major && st.tally != CFR_TALLY_MAX
      |=> st.tally == $past(st.tally) + CFR_TALLY_MINOR;
   endproperty
   a_tally_minor: assert property (p_tally_minor) else $error("minor error step wrong");

   property p_tally_success;
      ce && rx_err.success && !rx_err.major && !rx_err.minor && st.tally > CFR_PASSIVE_LIMIT
      |=> st.tally == CFR_PASSIVE_LIMIT;
   endproperty
   a_tally_success: assert property (p_tally_success) else $error("success above limit wrong");

   property p_tally_decrement;
      ce && rx_err.success && !rx_err.major && !rx_err.minor && st.tally <= CFR_PASSIVE_LIMIT && st.tally != 8'h00
      |=> st.tally == $past(st.tally) - CFR_TALLY_MINOR;
   endproperty
   a_tally_decrement: assert property (p_tally_decrement) else $error("success step wrong");

   property p_tally_floor;
      ce && rx_err.success && !rx_err.major && !rx_err.minor && st.tally == 8'h00
      |=> st.tally == 8'h00;
   endproperty
   a_tally_floor: assert property (p_tally_floor) else $error("tally went below zero");

   property p_tally_quiet;
      ce && !rx_err.major && !rx_err.minor && !rx_err.success |=> $stable(st.tally);
   endproperty
   a_tally_quiet: assert property (p_tally_quiet) else $error("tally moved without event");

   property p_passive_event;
      ce && !st.passive && st.tally > CFR_PASSIVE_LIMIT && !(take_rd && a == CFR_OFS_STATUS)
      |=> st.status[CFR_ST_PASSIVE];
   endproperty
   a_passive_event: assert property (p_passive_event) else $error("passive entry not reported");

   property p_no_busoff;
      ce && st.tally == CFR_TALLY_MAX && rx_err.minor && !rx_err.major
      |=> st.tally == CFR_TALLY_MAX && error_passive;
   endproperty
   a_no_busoff: assert property (p_no_busoff) else $error("tally left passive at top");

   property p_passive_other;
      ce && other_passive |=> error_passive;
   endproperty
   a_passive_other: assert property (p_passive_other) else $error("other passive source ignored");

   property p_kind_other;
      ce && rx_id.valid && rx_id.ext != st.f_id_low[1][CFR_SIDL_EXT_BIT] |=> !accept_hits[1];
   endproperty
   a_kind_other: assert property (p_kind_other) else $error("wrong frame kind accepted");

   property p_valid_only;
      ce && !rx_id.valid |=> !accept_valid && accept_hits == '0;
   endproperty
   a_valid_only: assert property (p_valid_only) else $error("result without identifier");

   property p_std_high;
      ce && rx_id.valid && !rx_id.ext && ((rx_id.id[28:21] ^ st.f_id_high[0]) & st.m_id_high[0]) != 8'h00
      |=> !accept_hits[0];
   endproperty
   a_std_high: assert property (p_std_high) else $error("standard high bits ignored");

   property p_ext_top;
      ce && rx_id.valid && rx_id.ext && ((rx_id.id[28:21] ^ st.f_id_high[0]) & st.m_id_high[0]) != 8'h00
      |=> !accept_hits[0];
   endproperty
   a_ext_top: assert property (p_ext_top) else $error("extended top bits ignored");

   property p_ext_second;
      ce && rx_id.valid && rx_id.ext && ((rx_id.id[15:8] ^ st.f_ext_high[0]) & mask_ext_lower[0][15:8]) != 8'h00
      |=> !accept_hits[0];
   endproperty
   a_ext_second: assert property (p_ext_second) else $error("extended second byte ignored");

   property p_ext_lowbyte;
      ce && rx_id.valid && rx_id.ext && ((rx_id.id[7:0] ^ st.f_ext_low[0]) & mask_ext_lower[0][7:0]) != 8'h00
      |=> !accept_hits[0];
   endproperty
   a_ext_lowbyte: assert property (p_ext_lowbyte) else $error("extended low byte ignored");

   property p_pair_bits;
      ce && rx_id.valid && rx_id.ext && ((rx_id.id[17:16] ^ st.f_id_low[0][1:0]) & mask_ext_lower[0][17:16]) != 2'h0
      |=> !accept_hits[0];
   endproperty
   a_pair_bits: assert property (p_pair_bits) else $error("extended pair bits ignored");

   property p_match;
      ce && rx_id.valid && !rx_id.ext && !st.f_id_low[0][CFR_SIDL_EXT_BIT] && ((rx_id.id[28:18]
      ^ {st.f_id_high[0], st.f_id_low[0][7:5]}) & {st.m_id_high[0], st.m_id_low[0][7:5]}) == 11'h000 |=> accept_hits[0];
   endproperty
   a_match: assert property (p_match) else $error("matching frame rejected");

   property p_match_mask1;
      ce && rx_id.valid && !rx_id.ext && !st.f_id_low[2][CFR_SIDL_EXT_BIT] && ((rx_id.id[28:18]
      ^ {st.f_id_high[2], st.f_id_low[2][7:5]}) & {st.m_id_high[1], st.m_id_low[1][7:5]}) == 11'h000 |=> accept_hits[2];
   endproperty
   a_match_mask1: assert property (p_match_mask1) else $error("matching frame rejected by second mask");

   property p_mask_high_write;
      ce && st.ap_wr && st.ap_addr[11:4] == CFR_PAGE_MASK && !st.ap_addr[2]
      |=> st.m_id_high[$past(st.ap_addr[3])] == $past(hwdata[7:0]);
   endproperty
   a_mask_high_write: assert property (p_mask_high_write) else $error("mask high byte not stored");

   property p_mask_low_write;
      ce && st.ap_wr && st.ap_addr[11:4] == CFR_PAGE_MASK && st.ap_addr[2]
      |=> st.m_id_low[$past(st.ap_addr[3])] == ($past(hwdata[7:0]) & CFR_MASK_LOW_WMASK);
   endproperty
   a_mask_low_write: assert property (p_mask_low_write) else $error("mask low byte not stored");

   property p_ext_high_write;
      ce && st.ap_wr && st.ap_addr[11:7] == CFR_PAGE_FILTER && int'(st.ap_addr[6:4]) < CFR_NFILT
      && st.ap_addr[3:2] == CFR_FREG_EXT_HIGH |=> st.f_ext_high[$past(st.ap_addr[6:4])] == $past(hwdata[7:0]);
   endproperty
   a_ext_high_write: assert property (p_ext_high_write) else $error("filter ext high not stored");

   property p_ext_low_write;
      ce && st.ap_wr && st.ap_addr[11:7] == CFR_PAGE_FILTER && int'(st.ap_addr[6:4]) < CFR_NFILT
      && st.ap_addr[3:2] == CFR_FREG_EXT_LOW |=> st.f_ext_low[$past(st.ap_addr[6:4])] == $past(hwdata[7:0]);
   endproperty
   a_ext_low_write: assert property (p_ext_low_write) else $error("filter ext low not stored");

   property p_low_write;
      ce && st.ap_wr && st.ap_addr[11:7] == CFR_PAGE_FILTER && int'(st.ap_addr[6:4]) < CFR_NFILT
      && st.ap_addr[3:2] == CFR_FREG_ID_LOW
      |=> st.f_id_low[$past(st.ap_addr[6:4])] == ($past(hwdata[7:0]) & CFR_FILTER_LOW_WMASK);
   endproperty
   a_low_write: assert property (p_low_write) else $error("filter low byte holes written");

   property p_mask_holes;
      ce && take_rd && a[11:4] == CFR_PAGE_MASK && a[2] |=> hrdata[4:2] == 3'h0;
   endproperty
   a_mask_holes: assert property (p_mask_holes) else $error("mask low holes not zero");

   property p_bus_okay;
      hreadyout && !hresp;
   endproperty
   a_bus_okay: assert property (p_bus_okay) else $error("bus response not ready and okay");
endmodule

// File: cfr_pkg.sv
// Constants and carrier types for the CAN receive filter and error register block
package cfr_pkg;
   localparam int CFR_NBUF = 2;
   localparam int CFR_NBYTE = 8;
   localparam int CFR_NFILT = 6;
   localparam int CFR_NMASK = 2;
   localparam int CFR_MASK0_FILTERS = 2;
   localparam int CFR_AW = 12;
   // Byte addresses of single registers and upper address bits of register pages
   localparam logic [11:0] CFR_OFS_TALLY = 12'h040;
   localparam logic [11:0] CFR_OFS_STATUS = 12'h044;
   localparam logic [11:0] CFR_OFS_IRQ_MASK = 12'h048;
   localparam logic [5:0] CFR_PAGE_PAYLOAD = 6'h00;
   localparam logic [4:0] CFR_PAGE_FILTER = 5'h01;
   localparam logic [7:0] CFR_PAGE_MASK = 8'h10;
   // Register index within a filter group
   localparam logic [1:0] CFR_FREG_ID_HIGH = 2'h0;
   localparam logic [1:0] CFR_FREG_ID_LOW = 2'h1;
   localparam logic [1:0] CFR_FREG_EXT_HIGH = 2'h2;
   localparam logic [1:0] CFR_FREG_EXT_LOW = 2'h3;
   // Field positions and write masks
   localparam int CFR_SIDL_EXT_BIT = 3;
   localparam logic [7:0] CFR_FILTER_LOW_WMASK = 8'hEB;
   localparam logic [7:0] CFR_MASK_LOW_WMASK = 8'hE3;
   localparam int CFR_ST_ACCEPT = 0;
   localparam int CFR_ST_PASSIVE = 1;
   localparam int CFR_NSTATUS = 2;
   // Error tally figures and the AHB-Lite NONSEQ transfer code
   localparam logic [7:0] CFR_PASSIVE_LIMIT = 8'h7F;
   localparam logic [7:0] CFR_TALLY_MAX = 8'hFF;
   localparam logic [7:0] CFR_TALLY_MAJOR = 8'h08;
   localparam logic [7:0] CFR_TALLY_MINOR = 8'h01;
   localparam logic [1:0] CFR_HTRANS_NONSEQ = 2'h2;

   typedef struct packed {
      logic valid;
      logic ext;
      logic [28:0] id;
   } cfr_rxid_s;

   typedef struct packed {
      logic minor;
      logic major;
      logic success;
   } cfr_errev_s;

   typedef struct packed {
      logic ready;
      logic resp;
      logic [31:0] rdata;
      logic ap_wr;
      logic [11:0] ap_addr;
      logic [CFR_NBUF*CFR_NBYTE-1:0][7:0] payload;
      logic [7:0] tally;
      logic [CFR_NFILT-1:0][7:0] f_id_high;
      logic [CFR_NFILT-1:0][7:0] f_id_low;
      logic [CFR_NFILT-1:0][7:0] f_ext_high;
      logic [CFR_NFILT-1:0][7:0] f_ext_low;
      logic [CFR_NMASK-1:0][7:0] m_id_high;
      logic [CFR_NMASK-1:0][7:0] m_id_low;
      logic [CFR_NSTATUS-1:0] status;
      logic [CFR_NSTATUS-1:0] irq_mask;
      logic passive;
      logic irq;
      logic acc_valid;
      logic [CFR_NFILT-1:0] acc_hits;
   } cfr_state_s;

   localparam cfr_state_s CFR_ST_RESET = '{ready: 1'b1, default: '0};
endpackage

// File: cfr_far.sv
// Far-side model: protocol engine events, received identifiers and payload bytes
`timescale 1ns/1ps
module cfr_far
   import cfr_pkg::*;
(
   input wire logic clk,
   output cfr_pkg::cfr_rxid_s rx_id,
   output cfr_pkg::cfr_errev_s rx_err,
   output logic byte_we,
   output logic [3:0] byte_sel,
   output logic [7:0] byte_data
);
   initial begin
      rx_id = '0;
      rx_err = '0;
      byte_we = 1'b0;
      byte_sel = 4'h0;
      byte_data = 8'h00;
   end
   // One identifier per call; released fields show the inverse
   task automatic send_id(input logic e, input logic [28:0] i);
      @(posedge clk);
      rx_id <= '{valid: 1'b1, ext: e, id: i};
      @(posedge clk);
      rx_id <= '{valid: 1'b0, ext: ~e, id: ~i};
   endtask
   // Error events as single-cycle pulses, n of them
   task automatic err(input cfr_errev_s e, input int n);
      repeat (n) begin
         @(posedge clk);
         rx_err <= e;
         @(posedge clk);
         rx_err <= '0;
      end
   endtask
   task automatic put_byte(input logic [3:0] s, input logic [7:0] d);
      @(posedge clk);
      byte_we <= 1'b1;
      byte_sel <= s;
      byte_data <= d;
      @(posedge clk);
      byte_we <= 1'b0;
      byte_data <= ~d;
   endtask
endmodule

// File: tb.sv
// Self-checking bench for the receive filter and error register block
`timescale 1ns/1ps
module tb;
   import cfr_pkg::*;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = '0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = '0;
   logic other_passive = 1'b0;
   logic [31:0] hrdata, rd;
   logic hreadyout, hresp, error_passive, accept_valid, irq, byte_we;
   logic [5:0] accept_hits;
   logic [3:0] byte_sel;
   logic [7:0] byte_data;
   cfr_rxid_s rx_id;
   cfr_errev_s rx_err;
   int mismatches = 0;
   int n_compared = 0;
   localparam logic [28:0] EXT_ID = {8'h12, 3'h5, 2'h3, 16'h3456};
   logic [11:0] r_addr [8] = '{12'h000, 12'h03C, 12'h084, 12'h104, 12'h088, 12'h08C, 12'h040, 12'h200};
   logic [7:0] r_wr [8] = '{8'hA5, 8'h5A, 8'hFF, 8'hFF, 8'hC3, 8'h3C, 8'hFF, 8'hFF};
   logic [7:0] r_exp [8] = '{8'hA5, 8'h5A, 8'hEB, 8'hE3, 8'hC3, 8'h3C, 8'h00, 8'h00};
   logic [11:0] c_addr [8] = '{12'h080, 12'h084, 12'h090, 12'h094, 12'h098, 12'h09C, 12'h100, 12'h104};
   logic [7:0] c_dat [8] = '{8'h12, 8'hA0, 8'h12, 8'hAB, 8'h34, 8'h56, 8'hFF, 8'hE3};
   logic [29:0] i_id [7] = '{{1'b0, 11'h095, 18'h0}, {1'b0, 11'h094, 18'h0}, {1'b0, 11'h295, 18'h0},
      {1'b1, EXT_ID}, {1'b1, EXT_ID ^ 29'h10000}, {1'b1, EXT_ID ^ 29'h40000}, {1'b1, EXT_ID ^ 29'h100}};
   logic [5:0] i_exp [7] = '{6'h3D, 6'h3C, 6'h3C, 6'h02, 6'h00, 6'h00, 6'h00};

   always #5 hclk = ~hclk;

   cfr_top dut_u (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .rx_id(rx_id), .rx_err(rx_err), .rx_byte_we(byte_we),
      .rx_byte_sel(byte_sel), .rx_byte_data(byte_data), .mask_ext_lower({2{18'h3FFFF}}),
      .other_passive(other_passive), .error_passive(error_passive), .accept_valid(accept_valid),
      .accept_hits(accept_hits), .irq(irq));
   cfr_far far_u (.clk(hclk), .rx_id(rx_id), .rx_err(rx_err), .byte_we(byte_we), .byte_sel(byte_sel),
      .byte_data(byte_data));

   task automatic report_and_stop();
      if (mismatches == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         mismatches++;
         $display("Error %s expected %h seen %h", s, e, g);
      end
   endtask
   // Single AHB-Lite word transfer; read data lands in rd
   task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= CFR_HTRANS_NONSEQ;
      hwrite <= w;
      haddr <= {20'h0, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic rc(input logic [11:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      chk($sformatf("register %h", a), {24'h0, e}, rd);
   endtask
   task automatic flag(input string s, input logic e, input logic g);
      chk(s, {31'h0, e}, {31'h0, g});
   endtask
   task automatic settle();
      repeat (3) @(posedge hclk);
   endtask

   initial begin
      #50us;
      mismatches++;
      report_and_stop();
   end

   initial begin
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      rc(CFR_OFS_TALLY, 8'h00);
      for (int k = 0; k < 8; k++) begin
         bus(1'b1, r_addr[k], r_wr[k]);
         rc(r_addr[k], r_exp[k]);
      end
      far_u.put_byte(4'h9, 8'h77);
      rc(12'h024, 8'h77);
      for (int k = 0; k < 8; k++) bus(1'b1, c_addr[k], c_dat[k]);
      for (int k = 0; k < 7; k++) begin
         far_u.send_id(i_id[k][29], i_id[k][28:0]);
         #1;
         flag("accept_valid", 1'b1, accept_valid);
         chk("accept_hits", {26'h0, i_exp[k]}, {26'h0, accept_hits});
      end
      // Interrupt masked, status read clears, then unmasked
      settle();
      flag("irq", 1'b0, irq);
      rc(CFR_OFS_STATUS, 8'h01);
      rc(CFR_OFS_STATUS, 8'h00);
      bus(1'b1, CFR_OFS_IRQ_MASK, 8'h03);
      far_u.send_id(1'b0, {11'h095, 18'h0});
      settle();
      flag("irq", 1'b1, irq);
      rc(CFR_OFS_STATUS, 8'h01);
      settle();
      flag("irq", 1'b0, irq);
      // Error tally up to the passive boundary and back
      far_u.err(3'b010, 15);
      far_u.err(3'b100, 7);
      settle();
      rc(CFR_OFS_TALLY, 8'h7F);
      flag("error_passive", 1'b0, error_passive);
      far_u.err(3'b100, 1);
      settle();
      rc(CFR_OFS_TALLY, 8'h80);
      flag("error_passive", 1'b1, error_passive);
      flag("irq", 1'b1, irq);
      rc(CFR_OFS_STATUS, 8'h02);
      far_u.err(3'b001, 1);
      settle();
      rc(CFR_OFS_TALLY, 8'h7F);
      flag("error_passive", 1'b0, error_passive);
      other_passive <= 1'b1;
      settle();
      flag("error_passive", 1'b1, error_passive);
      other_passive <= 1'b0;
      settle();
      flag("error_passive", 1'b0, error_passive);
      far_u.err(3'b010, 20);
      settle();
      rc(CFR_OFS_TALLY, 8'hFF);
      flag("error_passive", 1'b1, error_passive);
      flag("hresp", 1'b0, hresp);
      // Reset in mid-run clears tally, passive and interrupt
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      flag("error_passive", 1'b0, error_passive);
      flag("irq", 1'b0, irq);
      hresetn <= 1'b1;
      rc(CFR_OFS_TALLY, 8'h00);
      report_and_stop();
   end
endmodule
